// ===== design/gtu_pkg.sv
// constants, types and register map of the general timer unit
package gtu_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER   = 2'b00,
    MODE_GATED   = 2'b01,
    MODE_COUNTER = 2'b10,
    MODE_INCR    = 2'b11
  } gtu_mode_t;

  // per-timer control word, bit 0 at the bottom
  typedef struct packed {
    logic ovf_reload;
    logic trig_dir;
    logic trig_cnt;
    logic cap_clear;
    logic rl_ext;
    logic rl_fall;
    logic rl_rise;
    logic latch_clk;
    logic aux_reload;
    logic aux_en;
    logic [1:0] edge_sel;
    logic gate_pol;
    logic [2:0] prescale;
    logic ext_dir;
    logic down;
    logic run;
    gtu_mode_t mode;
  } gtu_ctrl_t;

  // pin order: core, aux a, aux b, capture, overflow; no capture timer direction pin
  typedef struct packed {
    logic [4:0] cnt_in;
    logic [3:0] dir_in;
    logic cap_in;
  } gtu_pins_t;

  localparam int NUM_TMR = 5;
  localparam int CORE = 0;
  localparam int AUXA = 1;
  localparam int AUXB = 2;
  localparam int CAPT = 3;
  localparam int OVFT = 4;
  localparam int ADDR_W = 6;
  localparam int PRE_W = 10;
  localparam int CTRL_W = $bits(gtu_ctrl_t);
  localparam int RES1_CYC = 4;
  localparam int RES2_CYC = 2;
  localparam logic [5:0] OFS_TMR_BASE = 6'h00;
  localparam logic [5:0] TMR_STRIDE = 6'h08;
  localparam logic [5:0] OFS_CNT = 6'h04;
  localparam logic [5:0] OFS_CAPTURE_RELOAD_REGISTER = 6'h28;
  localparam logic [5:0] OFS_STATUS = 6'h2C;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
  localparam gtu_ctrl_t CTRL_RST = '0;

endpackage : gtu_pkg

// ===== design/gtu_top.sv
// general timer unit: five 16-bit timers in two modules behind an avalon-mm slave
//
// Operation
// - five 16-bit timers in two modules, each alone or chained in its module.
// - first-module timers each select timer, gated, counter or incremental mode.
// - timer mode counts prescaled system clock ticks up or down.
// - counter mode counts edges seen on the timer's count pin.
// - gated mode runs only while the gate pin holds the enabling level.
// - first-module timers step at most once every 4 clocks in timer and gated modes.
// - direction set by software or flipped by the direction pin.
// - incremental mode decodes quadrature on count and direction pins.
// - core toggle latch flips on every core wrap, drives pin, clocks auxiliaries.
// - auxiliary timer in capture or reload role stops counting.
// - capture role copies core count on an edge at the aux pin.
// - reload role loads core on pin edge or chosen latch transition.
// - opposite latch transitions on both auxiliaries alternate reloads for pwm.
// - second module has two timers and capture/reload register, 2-clock resolution.
// - second-module timers use prescaled clock or external signals.
// - overflow toggle latch flips on wrap, clocks capture timer, drives pin.
// - overflow timer wraps feed capture compare clock and reload from register.
// - capture pin edge latches capture timer, optionally clearing it.
// - core count or direction pin transitions may also trigger that capture.
// - capture timer direction comes from software only, never a pin.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module gtu_top (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [gtu_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire gtu_pkg::gtu_pins_t PINS_I,
  output logic CORE_TOGGLE_OUTPUT_O,
  output logic OVERFLOW_TOGGLE_OUTPUT_O,
  output logic CCU_CLOCK_EVENT_O
);
  import gtu_pkg::*;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b+:8] = wd[8*b+:8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic edg(input logic [1:0] sel, input logic now, input logic old);
    return (sel[0] & now & !old) | (sel[1] & !now & old);
  endfunction : edg

  ////////////////////////////////////////////////////////////////////////////
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic wr_go;
  logic wr_cap;
  logic [NUM_TMR-1:0] wr_ctl;
  logic [NUM_TMR-1:0] wr_cnt;
  gtu_pins_t s1_q;
  gtu_pins_t s2_q;
  gtu_pins_t s3_q;
  logic [PRE_W-1:0] pre_q;
  logic core_toggle_latch_q;
  logic core_latch_old_q;
  logic overflow_toggle_latch_q;
  logic ovf_latch_old_q;
  logic ccu_event_q;
  logic [15:0] capture_reload_q;
  logic [31:0] cap_m;
  logic [4:0] cnt_now;
  logic [4:0] cnt_old;
  logic [4:0] dir_now;
  logic [4:0] dir_old;
  logic [NUM_TMR-1:0] ovf_w;
  logic [NUM_TMR-1:0] step_w;
  logic [NUM_TMR-1:0] dn_w;
  logic [NUM_TMR-1:0] load_en;
  logic [15:0] load_val [NUM_TMR];
  logic [15:0] cnt_w [NUM_TMR];
  gtu_ctrl_t ctrl_w [NUM_TMR];
  logic [2:1] rl_hit;
  logic [2:1] cap_hit;
  logic cap_trig;
  logic lrise;
  logic lfall;

  ////////////////////////////////////////////////////////////////////////////
  // one wait state: read data are registered so they stand at the release edge
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & !ack_q;
  assign wr_go = AVS_WRITE_I & ack_q;
  assign wr_cap = wr_go & (AVS_ADDRESS_I == OFS_CAPTURE_RELOAD_REGISTER);
  assign AVS_READDATA_O = rdata_q;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & !ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_TMR; i++) begin
      if (AVS_ADDRESS_I == ADDR_W'(OFS_TMR_BASE + TMR_STRIDE * i)) begin
        rd_mux = 32'(ctrl_w[i]);
      end
      if (AVS_ADDRESS_I == ADDR_W'(OFS_TMR_BASE + TMR_STRIDE * i + OFS_CNT)) begin
        rd_mux = {16'h0000, cnt_w[i]};
      end
    end
    if (AVS_ADDRESS_I == OFS_CAPTURE_RELOAD_REGISTER) begin
      rd_mux = {16'h0000, capture_reload_q};
    end
    if (AVS_ADDRESS_I == OFS_STATUS) begin
      rd_mux = {30'h0000_0000, overflow_toggle_latch_q, core_toggle_latch_q};
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ_I && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // s3 is only a history stage for edge detection on the already clean s2
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= PINS_I;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cnt_now = s2_q.cnt_in;
  assign cnt_old = s3_q.cnt_in;
  // capture timer direction slot has no pin behind it
  assign dir_now = {s2_q.dir_in[3], 1'b0, s2_q.dir_in[2:0]};
  assign dir_old = {s3_q.dir_in[3], 1'b0, s3_q.dir_in[2:0]};

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pre_q <= PRE_RST;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      core_toggle_latch_q <= 1'b0;
      core_latch_old_q <= 1'b0;
      overflow_toggle_latch_q <= 1'b0;
      ovf_latch_old_q <= 1'b0;
      ccu_event_q <= 1'b0;
    end else begin
      core_toggle_latch_q <= core_toggle_latch_q ^ ovf_w[CORE];
      core_latch_old_q <= core_toggle_latch_q;
      overflow_toggle_latch_q <= overflow_toggle_latch_q ^ ovf_w[OVFT];
      ovf_latch_old_q <= overflow_toggle_latch_q;
      ccu_event_q <= ovf_w[OVFT];
    end
  end

  assign CORE_TOGGLE_OUTPUT_O = core_toggle_latch_q;
  assign OVERFLOW_TOGGLE_OUTPUT_O = overflow_toggle_latch_q;
  assign CCU_CLOCK_EVENT_O = ccu_event_q;

  ////////////////////////////////////////////////////////////////////////////
  assign lrise = ovf_w[CORE] & !core_toggle_latch_q;
  assign lfall = ovf_w[CORE] & core_toggle_latch_q;

  always_comb begin
    for (int j = AUXA; j <= AUXB; j++) begin
      rl_hit[j] = ctrl_w[j].aux_en & ctrl_w[j].aux_reload &
                  ((ctrl_w[j].rl_ext & edg(ctrl_w[j].edge_sel, cnt_now[j], cnt_old[j])) |
                   (ctrl_w[j].rl_rise & lrise) | (ctrl_w[j].rl_fall & lfall));
      cap_hit[j] = ctrl_w[j].aux_en & !ctrl_w[j].aux_reload &
                   edg(ctrl_w[j].edge_sel, cnt_now[j], cnt_old[j]);
    end
  end

  assign cap_trig = edg(ctrl_w[CAPT].edge_sel, s2_q.cap_in, s3_q.cap_in) |
                    (ctrl_w[CAPT].trig_cnt & (cnt_now[CORE] ^ cnt_old[CORE])) |
                    (ctrl_w[CAPT].trig_dir & (dir_now[CORE] ^ dir_old[CORE]));

  // aux a wins when both reload at the same edge
  always_comb begin
    load_en[CORE] = rl_hit[AUXA] | rl_hit[AUXB];
    load_val[CORE] = rl_hit[AUXA] ? cnt_w[AUXA] : cnt_w[AUXB];
    load_en[AUXA] = cap_hit[AUXA];
    load_val[AUXA] = cnt_w[CORE];
    load_en[AUXB] = cap_hit[AUXB];
    load_val[AUXB] = cnt_w[CORE];
    load_en[CAPT] = cap_trig & ctrl_w[CAPT].cap_clear;
    load_val[CAPT] = CNT_RST;
    load_en[OVFT] = ctrl_w[OVFT].ovf_reload & ovf_w[OVFT];
    load_val[OVFT] = capture_reload_q;
  end

  // a capture beats a bus write in the same cycle
  assign cap_m = be_merge({16'h0000, capture_reload_q}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      capture_reload_q <= CNT_RST;
    end else if (cap_trig) begin
      capture_reload_q <= cnt_w[CAPT];
    end else if (wr_cap) begin
      capture_reload_q <= cap_m[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    localparam int RES = (i < CAPT) ? RES1_CYC : RES2_CYC;
    localparam logic FIRST = (i < CAPT);
    localparam logic CHAIN = (i >= AUXA) && (i <= CAPT);
    gtu_ctrl_t ctl_q;
    logic [15:0] cnt_q;
    logic [31:0] ctl_m;
    logic [31:0] cnt_m;
    logic [PRE_W-1:0] div;
    logic tick;
    logic src_now;
    logic src_old;
    logic quad;
    logic step;
    logic dn;
    logic active;

    assign wr_ctl[i] = wr_go & (AVS_ADDRESS_I == ADDR_W'(OFS_TMR_BASE + TMR_STRIDE * i));
    assign wr_cnt[i] = wr_go &
                       (AVS_ADDRESS_I == ADDR_W'(OFS_TMR_BASE + TMR_STRIDE * i + OFS_CNT));
    assign ctl_m = be_merge(32'(ctl_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
    assign cnt_m = be_merge({16'h0000, cnt_q}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

    // the prescaler never divides below the module's finest step
    assign div = PRE_W'(RES << ctl_q.prescale);
    assign tick = (pre_q & (div - 10'h001)) == PRE_RST;

    // chained timers count transitions of the partner latch instead of the pin
    assign src_now = (CHAIN && ctl_q.latch_clk) ?
                     ((i == CAPT) ? overflow_toggle_latch_q : core_toggle_latch_q) :
                     cnt_now[i];
    assign src_old = (CHAIN && ctl_q.latch_clk) ?
                     ((i == CAPT) ? ovf_latch_old_q : core_latch_old_q) : cnt_old[i];
    assign quad = FIRST & ((cnt_now[i] ^ cnt_old[i]) | (dir_now[i] ^ dir_old[i]));

    always_comb begin
      unique case (ctl_q.mode)
        MODE_TIMER: step = tick;
        MODE_GATED: step = tick & (cnt_now[i] == ctl_q.gate_pol);
        MODE_COUNTER: step = edg(ctl_q.edge_sel, src_now, src_old);
        MODE_INCR: step = quad;
      endcase
    end

    // leading a gives up; down bit inverts the sense
    assign dn = (FIRST && ctl_q.mode == MODE_INCR) ?
                (ctl_q.down ^ !(cnt_now[i] ^ dir_old[i])) :
                (ctl_q.down ^ (ctl_q.ext_dir & dir_now[i]));
    assign active = ctl_q.run & !(ctl_q.aux_en && (i == AUXA || i == AUXB));
    assign ovf_w[i] = active & step & (dn ? (cnt_q == CNT_RST) : (cnt_q == CNT_MAX));
    assign step_w[i] = active & step;
    assign dn_w[i] = dn;
    assign cnt_w[i] = cnt_q;
    assign ctrl_w[i] = ctl_q;

    always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
        ctl_q <= CTRL_RST;
      end else if (wr_ctl[i]) begin
        ctl_q <= gtu_ctrl_t'(ctl_m[CTRL_W-1:0]);
      end
    end

    // wrap falls out of 16-bit arithmetic
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
        cnt_q <= CNT_RST;
      end else if (wr_cnt[i]) begin
        cnt_q <= cnt_m[15:0];
      end else if (load_en[i]) begin
        cnt_q <= load_val[i];
      end else if (active && step) begin
        cnt_q <= dn ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_core_step;
    step_w[CORE] && ctrl_w[CORE].mode == MODE_TIMER && !wr_ctl[CORE];
  endsequence

  sequence s_first_quiet;
    !step_w[CORE] [*3];
  endsequence

  a_core_latch_flip: assert property (
    ovf_w[CORE] |=> core_toggle_latch_q != $past(core_toggle_latch_q))
    else $error("core toggle latch did not flip on wrap");

  a_first_resolution: assert property (
    s_core_step |=> s_first_quiet)
    else $error("core timer stepped faster than every 4 clocks");

  a_second_resolution: assert property (
    step_w[OVFT] && ctrl_w[OVFT].mode == MODE_TIMER && !wr_ctl[OVFT] |=> !step_w[OVFT])
    else $error("overflow timer stepped faster than every 2 clocks");

  a_aux_hold: assert property (
    ctrl_w[AUXA].aux_en && !load_en[AUXA] && !wr_cnt[AUXA] |=> $stable(cnt_w[AUXA]))
    else $error("aux timer counted while in capture or reload role");

  a_aux_capture: assert property (
    cap_hit[AUXA] && !wr_cnt[AUXA] |=> cnt_w[AUXA] == $past(cnt_w[CORE]))
    else $error("aux timer did not capture core count");

  a_core_reload: assert property (
    load_en[CORE] && !wr_cnt[CORE] |=> cnt_w[CORE] == $past(load_val[CORE]))
    else $error("core timer did not take reload value");

  a_capreg_latch: assert property (
    cap_trig |=> capture_reload_q == $past(cnt_w[CAPT]))
    else $error("capture register did not latch capture timer");

  a_capt_clear: assert property (
    cap_trig && ctrl_w[CAPT].cap_clear && !wr_cnt[CAPT] |=> cnt_w[CAPT] == CNT_RST)
    else $error("capture timer not cleared after capture");

  a_ovf_reload: assert property (
    load_en[OVFT] && !wr_cnt[OVFT] |=> cnt_w[OVFT] == $past(capture_reload_q))
    else $error("overflow timer did not reload from capture register");

  a_capt_dir_soft: assert property (
    dn_w[CAPT] == ctrl_w[CAPT].down)
    else $error("capture timer direction followed a pin");

  a_core_wrap_up: assert property (
    ovf_w[CORE] && !dn_w[CORE] && !load_en[CORE] && !wr_cnt[CORE] |=> cnt_w[CORE] == CNT_RST)
    else $error("core timer did not wrap to zero");

  a_ovf_event_out: assert property (
    ovf_w[OVFT] |=> CCU_CLOCK_EVENT_O && overflow_toggle_latch_q != $past(overflow_toggle_latch_q))
    else $error("overflow wrap not signalled");

  a_bus_answer: assert property (
    AVS_READ_I || AVS_WRITE_I |-> ##[0:1] !AVS_WAITREQUEST_O)
    else $error("bus request not answered within one wait state");

endmodule : gtu_top

// ===== verif/gtu_pin_model.sv
// pin-side model of the timer unit: event, gate, direction and quadrature sources
`timescale 1ns/10ps
module gtu_pin_model (
  input wire logic clk_i,
  output gtu_pkg::gtu_pins_t pins_o
);
  import gtu_pkg::*;
  logic [9:0] pins_q = 10'h000;
  logic [1:0] phase = 2'h0;
  // pins are driven levels, so the last value simply stands between events
  assign pins_o = pins_q;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic lvl(input int b, input logic v);
    @(posedge clk_i);
    pins_q[b] <= v;
  endtask : lvl
  // 4 clocks high, 4 low: longer than the synchroniser needs to see each edge
  task automatic pulse(input int b, input int n);
    for (int i = 0; i < n; i++) begin
      lvl(b, 1'b1);
      repeat (3) @(posedge clk_i);
      lvl(b, 1'b0);
      repeat (3) @(posedge clk_i);
    end
  endtask : pulse
  // sensor signals a and b on core count and direction pins, gray order 00 10 11 01
  task automatic quad(input int n, input logic back);
    for (int i = 0; i < n; i++) begin
      phase = back ? phase - 2'h1 : phase + 2'h1;
      @(posedge clk_i);
      pins_q[5] <= phase[1] ^ phase[0];
      pins_q[1] <= phase[1];
      repeat (3) @(posedge clk_i);
    end
  endtask : quad
endmodule : gtu_pin_model

// ===== verif/test_general_purpose_timer_unit.sv
// self-checking bench for the general timer unit
`timescale 1ns/10ps
module test_general_purpose_timer_unit;
  import gtu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic wait_req;
  gtu_pins_t pins;
  logic core_tgl;
  logic ovf_tgl;
  logic ccu_evt;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h149E6FA8;
  int num_errors = 0;
  int checks = 0;
  int ccu_cnt = 0;

  always #4 clk = ~clk;

  gtu_top i_dut (
    .REF_CLK_I(clk),
    .RST_N_I(rst_n),
    .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd_en),
    .AVS_WRITE_I(wr_en),
    .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_req),
    .PINS_I(pins),
    .CORE_TOGGLE_OUTPUT_O(core_tgl),
    .OVERFLOW_TOGGLE_OUTPUT_O(ovf_tgl),
    .CCU_CLOCK_EVENT_O(ccu_evt)
  );

  gtu_pin_model i_pins (
    .clk_i(clk),
    .pins_o(pins)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    // a read whose answer never came counts as a mismatch
    if (exp_q.size() > 0) begin
      num_errors++;
    end
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // request held until waitrequest is seen low; one idle edge before the next
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wr_en <= w;
    rd_en <= ~w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // read data stand only at the edge that ends the wait
  always @(posedge clk) begin
    if (rd_en && wait_req === 1'b0 && exp_q.size() > 0) begin
      check("readdata", rdata, exp_q.pop_front());
    end
    if (ccu_evt === 1'b1) begin
      ccu_cnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [15:0] r;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(6'h00, 32'h0);
    rd(6'h04, 32'h0);
    rd(6'h2C, 32'h0);
    wr(6'h30, 32'hFFFFFFFF);
    rd(6'h30, 32'h0);
    $display("test reset done");
    // 40 clocks between the two control writes hold exactly 10 ticks
    wr(6'h04, 32'h0);
    wr(6'h00, 32'h4);
    repeat (37) @(posedge clk);
    wr(6'h00, 32'h0);
    rd(6'h04, 32'hA);
    wr(6'h04, 32'h3);
    wr(6'h00, 32'hC);
    repeat (37) @(posedge clk);
    wr(6'h00, 32'h0);
    rd(6'h04, 32'hFFF9);
    rd(6'h2C, 32'h1);
    check("core_toggle", {31'h0, core_tgl}, 32'h1);
    $display("test timer done");
    seed = xs(seed);
    n = int'(seed[2:0]) + 3;
    wr(6'h04, 32'h0);
    wr(6'h00, 32'h206);
    i_pins.pulse(5, n);
    rd(6'h04, 32'(n));
    wr(6'h00, 32'h216);
    i_pins.lvl(1, 1'b1);
    i_pins.pulse(5, 3);
    rd(6'h04, 32'(n - 3));
    i_pins.lvl(1, 1'b0);
    wr(6'h00, 32'h0);
    wr(6'h04, 32'h0);
    wr(6'h00, 32'h7);
    i_pins.quad(8, 1'b0);
    i_pins.quad(3, 1'b1);
    repeat (2) @(posedge clk);
    rd(6'h04, 32'h5);
    wr(6'h00, 32'h0);
    $display("test counter done");
    // aux a gated: closed gate holds it, open gate gives the plain tick rate
    wr(6'h0C, 32'h0);
    wr(6'h08, 32'h105);
    repeat (37) @(posedge clk);
    rd(6'h0C, 32'h0);
    i_pins.lvl(6, 1'b1);
    repeat (8) @(posedge clk);
    wr(6'h0C, 32'h0);
    repeat (37) @(posedge clk);
    wr(6'h08, 32'h0);
    rd(6'h0C, 32'hA);
    i_pins.lvl(6, 1'b0);
    $display("test gated done");
    seed = xs(seed);
    r = seed[15:0];
    wr(6'h04, {16'h0, r});
    wr(6'h08, 32'hA04);
    i_pins.pulse(6, 1);
    repeat (37) @(posedge clk);
    rd(6'h0C, {16'h0, r});
    wr(6'h08, 32'h0);
    wr(6'h14, 32'hABC);
    wr(6'h10, 32'h11A00);
    i_pins.pulse(7, 1);
    rd(6'h04, 32'hABC);
    wr(6'h10, 32'h0);
    $display("test capture reload done");
    wr(6'h1C, 32'h55);
    wr(6'h18, 32'h20200);
    i_pins.pulse(0, 1);
    rd(6'h28, 32'h55);
    rd(6'h1C, 32'h0);
    wr(6'h18, 32'h0);
    // 40 clocks give 20 ticks at the 2-clock rate, one wrap past 16'hFFFF
    wr(6'h24, 32'hFFF8);
    wr(6'h20, 32'h4);
    repeat (37) @(posedge clk);
    wr(6'h20, 32'h0);
    rd(6'h24, 32'hC);
    rd(6'h2C, 32'h3);
    check("ovf_toggle", {31'h0, ovf_tgl}, 32'h1);
    check("ccu_events", 32'(ccu_cnt), 32'h1);
    $display("test second module done");
    // core wraps once upward; aux a counts that latch edge
    wr(6'h04, 32'hFFFD);
    wr(6'h0C, 32'h0);
    wr(6'h08, 32'h2606);
    wr(6'h00, 32'h4);
    repeat (37) @(posedge clk);
    wr(6'h00, 32'h0);
    rd(6'h04, 32'h7);
    rd(6'h0C, 32'h1);
    check("core_toggle", {31'h0, core_tgl}, 32'h0);
    // aux a reloads on latch rise, aux b on fall: 10 ticks end on FFFC, latch low
    wr(6'h08, 32'h5800);
    wr(6'h0C, 32'hFFFE);
    wr(6'h10, 32'h9800);
    wr(6'h14, 32'hFFFC);
    wr(6'h04, 32'hFFFE);
    wr(6'h00, 32'h4);
    repeat (37) @(posedge clk);
    wr(6'h00, 32'h0);
    rd(6'h04, 32'hFFFC);
    rd(6'h2C, 32'h2);
    wr(6'h08, 32'h0);
    wr(6'h10, 32'h0);
    $display("test chaining done");
    // overflow timer reloads 16'h55 at its wrap; capture timer counts the latch edge
    wr(6'h1C, 32'h0);
    wr(6'h18, 32'h2606);
    wr(6'h24, 32'hFFF8);
    wr(6'h20, 32'h100004);
    repeat (37) @(posedge clk);
    wr(6'h20, 32'h0);
    rd(6'h24, 32'h61);
    rd(6'h1C, 32'h1);
    check("ovf_toggle", {31'h0, ovf_tgl}, 32'h0);
    check("ccu_events", 32'(ccu_cnt), 32'h2);
    wr(6'h18, 32'h40000);
    wr(6'h1C, 32'h77);
    i_pins.pulse(5, 1);
    rd(6'h28, 32'h77);
    wr(6'h18, 32'h80000);
    wr(6'h1C, 32'h99);
    i_pins.lvl(1, 1'b1);
    repeat (4) @(posedge clk);
    rd(6'h28, 32'h99);
    i_pins.lvl(1, 1'b0);
    wr(6'h18, 32'h0);
    $display("test overflow reload done");
    end_sim();
  end
endmodule : test_general_purpose_timer_unit
